// file: hw/fsc_pkg.sv
package fsc_pkg;

  // ----------------------------------------
  // Clock and power system timing
  // ----------------------------------------
  localparam longint CLK_HZ          = 25000000;
  localparam longint NOM_POWER_HZ    = 60;
  localparam int     SAMPLES_PER_CYC = 64;
  localparam int     GROUP_SAMPLES   = 4;
  // Nominal sample period as a 16.16 multiple of the clock period
  localparam logic [31:0] NOM_PERIOD_Q16 =
    32'((CLK_HZ * 64'd65536) / (NOM_POWER_HZ * SAMPLES_PER_CYC));
  // Longest silence on a channel before it is declared failed
  localparam longint MAX_GAP_US      = 66000;
  localparam int     MAX_GAP_CYCLES  = int'((MAX_GAP_US * CLK_HZ) / 1000000);

  // ----------------------------------------
  // Loop filter gains, signed with GAIN_SHIFT fraction bits
  // ----------------------------------------
  localparam int          GAIN_SHIFT        = 8;
  localparam logic [15:0] INTEGRAL_GAIN     = 16'h0004;
  localparam logic [15:0] PROPORTIONAL_GAIN = 16'h0040;
  localparam logic [15:0] FREQUENCY_GAIN    = 16'h0010;
  localparam logic [15:0] CLOCK_GAIN        = 16'h0100;

  // ----------------------------------------
  // Message handling and lock
  // ----------------------------------------
  localparam int         LOST_LIMIT_DEF  = 8;
  localparam int         SEQ_SPAN        = 16;
  localparam logic [3:0] SEQ_HALF        = 4'h8;
  localparam logic [15:0] LOCK_THRESHOLD = 16'h0100;
  localparam logic [7:0] STAMP_RESET     = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FSC_CLEAR  = 2'b00,
    FSC_LOAD   = 2'b01,
    FSC_FILTER = 2'b10,
    FSC_RUN    = 2'b11
  } fsc_phase_t;

  typedef struct packed {
    logic               valid;
    logic signed [15:0] phase_err;
  } fsc_phase_in_t;

  typedef struct packed {
    logic               present;
    logic signed [15:0] deviation;
  } fsc_freq_in_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] seq;
  } fsc_rx_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] seq;
    logic [7:0] stamp;
  } fsc_tx_t;

endpackage : fsc_pkg

// file: hw/fsc_sync.sv
// Function
// RQ1 - PI phase path, frequency into same integrator
// RQ2 - Frequency input zero without deviation measurement
// RQ3 - Four fixed gains set at design time
// RQ4 - Gains chosen for critically damped loop
// RQ5 - 16-bit sample counter reloaded every four samples; the code reloads it every sample and updates the reload value every four
// RQ6 - Period held as integer and fraction registers
// RQ7 - Fraction carry adds one to next reload
// RQ8 - Fraction accumulator never cleared in operation
// RQ9 - 8-bit stamp counts samples, wraps at 255
// RQ10 - Stamp wrap aligned to power cycle start
// RQ11 - Sequence number is stamp's top four bits
// RQ12 - Outgoing message carries sequence and stamp
// RQ13 - Message gap watchdog declares channel failure
// RQ14 - Lost message limit within sequence span
// RQ15 - Sequence gap flags a lost message
// RQ16 - Single loss suspends protection until next message
// RQ17 - Differential starts when all terminals match
// RQ18 - No deviation measured: track by phase alone
// RQ19 - Independent start-up, clock at nominal frequency
// RQ20 - Arriving messages put channel in service
// RQ21 - Low clock uncertainty declares lock, enables protection
// RQ22 - Sample strobe advances stamp and reload logic
module fsc_sync #(
  parameter int NCH        = 2,
  parameter int LOST_LIMIT = fsc_pkg::LOST_LIMIT_DEF,
  parameter int MAX_GAP    = fsc_pkg::MAX_GAP_CYCLES
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // Loop filter inputs, one filter step per tick while at least one channel is in service
  input  wire logic                  filter_tick,
  input  wire fsc_pkg::fsc_phase_in_t phase_in,
  input  wire fsc_pkg::fsc_freq_in_t  freq_in,
  input  wire logic [15:0]           clock_unc,
  // Received peer messages
  input  wire fsc_pkg::fsc_rx_t      rx [NCH],
  // Sampling and outgoing message
  output logic                       sample_strobe,
  output logic [7:0]                 time_stamp,
  output logic [3:0]                 seq_num,
  output fsc_pkg::fsc_tx_t           tx_msg,
  // Channel and protection status
  output logic [NCH-1:0]             chan_in_service,
  output logic [NCH-1:0]             chan_failed,
  output logic                       msg_lost,
  output logic                       protect_suspend,
  output logic                       diff_start,
  output logic [3:0]                 diff_seq,
  output logic                       locked,
  output logic                       protect_enable,
  output logic                       running
);
  import fsc_pkg::*;

  // ----------------------------------------
  // Derived constants
  // ----------------------------------------
  localparam int WD_W = $clog2(MAX_GAP + 1);
  // Span check keeps sequence matching unambiguous
  // RQ14 limit within span
  localparam int LOST_EFF = (LOST_LIMIT > SEQ_SPAN / 2) ? SEQ_SPAN / 2 : LOST_LIMIT;
  localparam logic [3:0]      LOST_LIM4 = 4'(LOST_EFF);
  localparam logic [WD_W-1:0] GAP_MAX   = WD_W'(MAX_GAP);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    fsc_phase_t                  phase;
    logic [3:0]                  clr_idx;
    logic [15:0]                 cnt;
    logic [15:0]                 reload;
    logic [1:0]                  grp;
    logic [15:0]                 period_int;
    logic [15:0]                 period_frac;
    logic [15:0]                 frac_acc;
    logic signed [31:0]          integ;
    logic [7:0]                  stamp;
    logic                        strobe;
    fsc_tx_t                     tx;
    logic [NCH-1:0][3:0]         last_seq;
    logic [NCH-1:0]              in_service;
    logic [NCH-1:0]              failed;
    logic [NCH-1:0]              suspend;
    logic [NCH-1:0][WD_W-1:0]    wd;
    logic [SEQ_SPAN-1:0][NCH:0]  match;
    logic                        diff;
    logic [3:0]                  diff_seq;
    logic                        lost;
    logic                        locked;
    logic                        prot_en;
    logic                        run;
    logic                        susp_any;
  } fsc_state_t;

  fsc_state_t s;
  fsc_state_t next_s;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Signed product scaled back by the gain fraction
  function automatic logic signed [31:0] gain_mul(input logic [15:0] g, input logic signed [15:0] x);
    logic signed [31:0] p;
    p = $signed(g) * x;
    return p >>> GAIN_SHIFT;
  endfunction

  // Messages missing between two sequence numbers, modulo the span
  function automatic logic [3:0] seq_gap(input logic [3:0] now_seq, input logic [3:0] prev_seq);
    return 4'(now_seq - prev_seq - 4'h1);
  endfunction

  logic signed [31:0] freq_term;
  logic signed [31:0] integ_new;
  logic signed [31:0] correction;
  logic [31:0]        period_q16;
  logic [16:0]        frac_sum;
  logic [NCH:0]       all_ones;

  always_comb begin
    next_s     = s;
    freq_term  = '0;
    integ_new  = s.integ;
    correction = '0;
    period_q16 = '0;
    frac_sum   = '0;
    all_ones   = '1;
    next_s.strobe = 1'b0;
    next_s.diff   = 1'b0;
    next_s.lost   = 1'b0;
    next_s.tx.valid = 1'b0;

    // ----------------------------------------
    // Start-up sequence
    // ----------------------------------------
    case (s.phase)
      // RQ19 clear buffer pointers
      FSC_CLEAR: begin
        next_s.match[s.clr_idx] = '0;
        next_s.clr_idx          = s.clr_idx + 4'h1;
        if (s.clr_idx == 4'hF) begin
          next_s.phase = FSC_LOAD;
        end
      end
      // RQ19 nominal frequency settings
      FSC_LOAD: begin
        next_s.period_int  = NOM_PERIOD_Q16[31:16];
        next_s.period_frac = NOM_PERIOD_Q16[15:0];
        next_s.reload      = NOM_PERIOD_Q16[31:16];
        next_s.cnt         = NOM_PERIOD_Q16[31:16];
        next_s.phase       = FSC_FILTER;
      end
      // RQ19 filter state initialised
      FSC_FILTER: begin
        next_s.integ = '0;
        next_s.phase = FSC_RUN;
      end
      default: begin
        next_s.phase = FSC_RUN;
      end
    endcase

    if (s.phase == FSC_RUN) begin
      // ----------------------------------------
      // Loop filter
      // ----------------------------------------
      // RQ2 zero without measurement
      // RQ18 phase-only tracking
      if (freq_in.present) begin
        freq_term = gain_mul(FREQUENCY_GAIN, freq_in.deviation);
      end
      if (filter_tick && |s.in_service) begin
        // RQ1 single shared integrator
        // RQ3 fixed design gains
        // RQ4 critically damped gains
        if (phase_in.valid) begin
          integ_new = s.integ + gain_mul(INTEGRAL_GAIN, phase_in.phase_err) + freq_term;
          correction = integ_new + gain_mul(PROPORTIONAL_GAIN, phase_in.phase_err);
        end else begin
          integ_new  = s.integ + freq_term;
          correction = integ_new;
        end
        next_s.integ = integ_new;
        // RQ6 integer and fraction registers
        period_q16 = NOM_PERIOD_Q16 - 32'((64'(signed'(correction)) * 64'(signed'(CLOCK_GAIN))) >>> GAIN_SHIFT);
        next_s.period_int  = period_q16[31:16];
        next_s.period_frac = period_q16[15:0];
      end

      // ----------------------------------------
      // Sample counter and stamps
      // ----------------------------------------
      // RQ5 counts out each sample period
      if (s.cnt <= 16'h0001) begin
        next_s.cnt    = s.reload;
        next_s.strobe = 1'b1;
        // RQ22 strobe advances stamp
        // RQ9 wraps 255 to zero
        // RQ10 zero at cycle start
        next_s.stamp = s.stamp + 8'h01;
        next_s.grp   = s.grp + 2'h1;
        if (s.grp == 2'(GROUP_SAMPLES - 1)) begin
          // RQ7 carry lengthens next group
          // RQ8 accumulator never cleared
          frac_sum        = {1'b0, s.frac_acc} + {1'b0, s.period_frac};
          next_s.frac_acc = frac_sum[15:0];
          next_s.reload   = s.period_int + {15'h0000, frac_sum[16]};
          next_s.cnt      = s.period_int + {15'h0000, frac_sum[16]};
        end
        // RQ11 top four stamp bits
        if (next_s.stamp[7:4] != s.stamp[7:4]) begin
          // RQ12 sequence plus stamp
          next_s.tx.valid = 1'b1;
          next_s.tx.seq   = next_s.stamp[7:4];
          next_s.tx.stamp = next_s.stamp;
          next_s.match[next_s.stamp[7:4]][0] = 1'b1;
          // Stale entry half a span away is retired before reuse
          next_s.match[next_s.stamp[7:4] + SEQ_HALF] = '0;
        end
      end else begin
        next_s.cnt = s.cnt - 16'h0001;
      end

      // ----------------------------------------
      // Channel supervision
      // ----------------------------------------
      for (int c = 0; c < NCH; c++) begin
        if (rx[c].valid) begin
          next_s.wd[c]     = '0;
          next_s.failed[c] = 1'b0;
          next_s.last_seq[c] = rx[c].seq;
          next_s.match[rx[c].seq][c + 1] = 1'b1;
          // RQ16 resume on next message
          next_s.suspend[c] = 1'b0;
          if (!s.in_service[c]) begin
            // RQ20 place channel in service
            next_s.in_service[c] = 1'b1;
          end else if (seq_gap(rx[c].seq, s.last_seq[c]) != 4'h0) begin
            // RQ15 gap means lost message
            next_s.lost = 1'b1;
            // RQ14 too many lost fails channel
            if (seq_gap(rx[c].seq, s.last_seq[c]) >= LOST_LIM4) begin
              next_s.failed[c]     = 1'b1;
              next_s.in_service[c] = 1'b0;
            end else begin
              // RQ16 suspend dependent computation
              next_s.suspend[c] = 1'b1;
            end
          end
        end else if (s.in_service[c]) begin
          // RQ13 watchdog on message gap
          if (s.wd[c] >= GAP_MAX) begin
            next_s.failed[c]     = 1'b1;
            next_s.in_service[c] = 1'b0;
            next_s.wd[c]         = '0;
          end else begin
            next_s.wd[c] = s.wd[c] + WD_W'(1);
          end
        end
      end

      // ----------------------------------------
      // Measurement matching
      // ----------------------------------------
      // RQ17 all terminals same sequence
      for (int q = 0; q < SEQ_SPAN; q++) begin
        if (!next_s.diff && next_s.match[q] == all_ones && s.prot_en && s.suspend == '0) begin
          next_s.diff     = 1'b1;
          next_s.diff_seq = 4'(q);
          next_s.match[q] = '0;
        end
      end

      // RQ21 lock below threshold
      next_s.locked  = (clock_unc < LOCK_THRESHOLD) && (|s.in_service);
      next_s.prot_en = next_s.locked;
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Registered here so every status output leaves a flip-flop
    next_s.run      = (next_s.phase == FSC_RUN);
    next_s.susp_any = |next_s.suspend;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // Start-up sequence begins from a known clear state
      s.phase       <= FSC_CLEAR;
      s.clr_idx     <= 4'h0;
      s.cnt         <= 16'h0000;
      s.reload      <= 16'h0000;
      s.grp         <= 2'h0;
      s.period_int  <= 16'h0000;
      s.period_frac <= 16'h0000;
      s.frac_acc    <= 16'h0000;
      s.integ       <= '0;
      s.stamp       <= STAMP_RESET;
      s.strobe      <= 1'b0;
      s.tx          <= '0;
      s.last_seq    <= '0;
      s.in_service  <= '0;
      s.failed      <= '0;
      s.suspend     <= '0;
      s.wd          <= '0;
      s.match       <= '0;
      s.diff        <= 1'b0;
      s.diff_seq    <= 4'h0;
      s.lost        <= 1'b0;
      s.locked      <= 1'b0;
      s.prot_en     <= 1'b0;
      s.run         <= 1'b0;
      s.susp_any    <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs, all taken from state flip-flops
  // ----------------------------------------
  assign sample_strobe   = s.strobe;
  assign time_stamp      = s.stamp;
  assign seq_num         = s.stamp[7:4];
  assign tx_msg          = s.tx;
  assign chan_in_service = s.in_service;
  assign chan_failed     = s.failed;
  assign msg_lost        = s.lost;
  assign protect_suspend = s.susp_any;
  assign diff_start      = s.diff;
  assign diff_seq        = s.diff_seq;
  assign locked          = s.locked;
  assign protect_enable  = s.prot_en;
  assign running         = s.run;

endmodule // fsc_sync

// file: testbench/fsc_chk.sv
module fsc_chk #(
  parameter int NCH     = 2,
  parameter int MAX_GAP = 200
) (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               nrst,
  // Block inputs
  input wire logic [15:0]        clock_unc,
  input wire fsc_pkg::fsc_rx_t   rx [NCH],
  // Block outputs
  input wire logic               sample_strobe,
  input wire logic [7:0]         time_stamp,
  input wire logic [3:0]         seq_num,
  input wire fsc_pkg::fsc_tx_t   tx_msg,
  input wire logic [NCH-1:0]     chan_in_service,
  input wire logic [NCH-1:0]     chan_failed,
  input wire logic               msg_lost,
  input wire logic               protect_suspend,
  input wire logic               diff_start,
  input wire logic               locked,
  input wire logic               protect_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  import fsc_pkg::*;
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic        rx_any;
  logic [31:0] quiet;
  always_comb begin
    rx_any = 1'b0;
    for (int c = 0; c < NCH; c++) rx_any = rx_any | rx[c].valid;
  end
  // Silence on channel 0; a few cycles of slack cover the registered outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) quiet <= 32'h0;
    else if (rx[0].valid || !chan_in_service[0]) quiet <= 32'h0;
    else quiet <= quiet + 32'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_seq_top;
    seq_num == time_stamp[7:4];
  endproperty
  a_seq_top: assert property (p_seq_top) else $error("seq not stamp top");
  property p_tx_pair;
    tx_msg.valid |-> tx_msg.seq == seq_num && tx_msg.stamp == time_stamp;
  endproperty
  a_tx_pair: assert property (p_tx_pair) else $error("message fields differ");
  property p_stamp_step;
    !$stable(time_stamp) |-> time_stamp == 8'($past(time_stamp) + 8'h01);
  endproperty
  a_stamp_step: assert property (p_stamp_step) else $error("stamp step");
  property p_strobe_gap;
    sample_strobe |=> !sample_strobe [*8];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobe too close");
  property p_lost_cause;
    msg_lost |-> $past(rx_any) || $past(rx_any, 2);
  endproperty
  a_lost_cause: assert property (p_lost_cause) else $error("loss without message");
  property p_lock;
    (clock_unc < LOCK_THRESHOLD && |chan_in_service) |=> locked;
  endproperty
  a_lock: assert property (p_lock) else $error("lock missing");
  property p_lock_enable;
    locked == protect_enable;
  endproperty
  a_lock_enable: assert property (p_lock_enable) else $error("enable differs");
  property p_fail_out;
    (chan_failed & chan_in_service) == '0;
  endproperty
  a_fail_out: assert property (p_fail_out) else $error("failed in service");
  property p_watchdog;
    quiet <= 32'(MAX_GAP + 4);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("silence not caught");
  property p_diff_gate;
    diff_start |-> $past(protect_enable) && !$past(protect_suspend);
  endproperty
  a_diff_gate: assert property (p_diff_gate) else $error("diff while blocked");
endmodule // fsc_chk

// file: testbench/fsc_peer.sv
module fsc_peer (
  // Clock
  input wire logic       core_clk,
  // Message toward the block
  output fsc_pkg::fsc_rx_t msg
);
  timeunit 1ns;
  timeprecision 1ns;
  import fsc_pkg::*;
  initial msg = '{valid: 1'b0, seq: 4'hF};
  // whole message, one cycle
  // Idle seq is inverted so a stale value never looks valid
  task automatic send(input logic [3:0] s);
    msg <= '{valid: 1'b1, seq: s};
    @(posedge core_clk);
    msg <= '{valid: 1'b0, seq: ~s};
  endtask
endmodule // fsc_peer

// file: testbench/tb_fractional_sample_clock_sync.sv
module tb_fractional_sample_clock_sync;
  timeunit 1ns;
  timeprecision 1ns;
  import fsc_pkg::*;
  localparam int GAP  = 200;
  localparam int PINT = int'(NOM_PERIOD_Q16[31:16]);
  logic          core_clk;
  logic          nrst;
  logic          filter_tick;
  fsc_phase_in_t phase_in;
  fsc_freq_in_t  freq_in;
  logic [15:0]   clock_unc;
  fsc_rx_t       rx [2];
  logic          sample_strobe;
  logic [7:0]    time_stamp;
  logic [3:0]    seq_num;
  logic [3:0]    diff_seq;
  fsc_tx_t       tx_msg;
  logic [1:0]    chan_in_service;
  logic [1:0]    chan_failed;
  logic          msg_lost;
  logic          protect_suspend;
  logic          diff_start;
  logic          locked;
  logic          protect_enable;
  logic          running;
  int            fail_count;
  int            cmp_count;
  int            lost_n;
  logic [15:0]   exp_int;
  logic [15:0]   exp_frac;
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (msg_lost === 1'b1) lost_n++;
  fsc_sync #(.NCH(2), .MAX_GAP(GAP)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .filter_tick(filter_tick), .phase_in(phase_in),
    .freq_in(freq_in), .clock_unc(clock_unc), .rx(rx), .sample_strobe(sample_strobe),
    .time_stamp(time_stamp), .seq_num(seq_num), .tx_msg(tx_msg), .chan_in_service(chan_in_service),
    .chan_failed(chan_failed), .msg_lost(msg_lost), .protect_suspend(protect_suspend),
    .diff_start(diff_start), .diff_seq(diff_seq), .locked(locked), .protect_enable(protect_enable),
    .running(running));
  fsc_peer u_peer0 (.core_clk(core_clk), .msg(rx[0]));
  fsc_peer u_peer1 (.core_clk(core_clk), .msg(rx[1]));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Reference gain product, floored like a fixed-point shift
  function automatic longint kmul(input longint g, input longint x);
    return (g * x) >>> GAIN_SHIFT;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tx(input int c, input logic [3:0] s);
    @(posedge core_clk);
    if (c == 1) u_peer1.send(s);
    else u_peer0.send(s);
    cyc(3);
  endtask
  task automatic close_out;
    $display("mismatches %0d compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    int n;
    cyc(6);
    chk({running, sample_strobe, time_stamp, chan_in_service}, 32'h0);
    nrst <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (running !== 1'b1 && n < 40);
    chk(n >= 16 && n <= 25, 32'h1);
    chk(time_stamp, 32'h0);
  endtask
  task automatic t_rx;
    longint      integ;
    logic [31:0] q;
    tx(0, 4'h3);
    tx(1, 4'h9);
    chk(chan_in_service, 32'h3);
    filter_tick <= 1'b1;
    phase_in    <= '{valid: 1'b1, phase_err: 16'sh7FFF};
    freq_in     <= '{present: 1'b1, deviation: 16'sh7FFF};
    cyc(8);
    freq_in     <= '{present: 1'b0, deviation: 16'sh8001};
    cyc(1);
    filter_tick <= 1'b0;
    integ = 8 * (kmul(INTEGRAL_GAIN, 32767) + kmul(FREQUENCY_GAIN, 32767)) + kmul(INTEGRAL_GAIN, 32767);
    q = 32'(longint'(NOM_PERIOD_Q16) - kmul(CLOCK_GAIN, integ + kmul(PROPORTIONAL_GAIN, 32767)));
    exp_int  = q[31:16];
    exp_frac = q[15:0];
    clock_unc <= 16'h0100;
    cyc(4);
    chk(locked, 32'h0);
    clock_unc <= 16'h00FF;
    cyc(4);
    chk({locked, protect_enable}, 32'h3);
    tx(0, 4'h4);
    chk(lost_n, 32'h0);
    tx(0, 4'h6);
    chk({lost_n[3:0], protect_suspend}, 32'h3);
    tx(0, 4'h7);
    chk(protect_suspend, 32'h0);
    tx(0, 4'h0);
    chk({chan_failed[0], chan_in_service[0]}, 32'h2);
    tx(0, 4'h1);
    chk({chan_failed[0], chan_in_service[0]}, 32'h1);
    cyc(GAP - 50);
    chk(chan_failed[0], 32'h0);
    cyc(100);
    chk({chan_failed[0], chan_in_service[0]}, 32'h2);
  endtask
  task automatic wait_strobe(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sample_strobe !== 1'b1 && n < 8000);
  endtask
  task automatic t_samples;
    int          n;
    int          want;
    logic [16:0] acc;
    want = PINT;
    acc  = '0;
    wait_strobe(n);
    for (int k = 1; k <= 8; k++) begin
      cyc(2);
      chk(time_stamp, 32'(k));
      // Every fourth strobe reloads from the period registers plus carry
      if (k % GROUP_SAMPLES == 0) begin
        acc  = {1'b0, acc[15:0]} + {1'b0, exp_frac};
        want = int'(exp_int) + int'(acc[16]);
      end
      wait_strobe(n);
      chk(32'(n + 2), 32'(want));
    end
  endtask
  initial begin
    nrst = 1'b0;
    filter_tick = 1'b0;
    phase_in = '0;
    freq_in = '0;
    clock_unc = 16'hFFFF;
    fail_count = 0;
    cmp_count = 0;
    lost_n = 0;
    t_reset();
    t_rx();
    t_samples();
    close_out();
  end
  initial begin
    #3_600_000;
    fail_count++;
    close_out();
  end
endmodule // tb_fractional_sample_clock_sync
bind fsc_sync fsc_chk #(.NCH(NCH), .MAX_GAP(MAX_GAP)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .clock_unc(clock_unc), .rx(rx), .sample_strobe(sample_strobe),
  .time_stamp(time_stamp), .seq_num(seq_num), .tx_msg(tx_msg), .chan_in_service(chan_in_service),
  .chan_failed(chan_failed), .msg_lost(msg_lost), .protect_suspend(protect_suspend),
  .diff_start(diff_start), .locked(locked), .protect_enable(protect_enable));
